// ===== design/adc_calc_defs.svh
// register map, field positions and reset values of the result computation unit
`ifndef ADC_CALC_DEFS_SVH
`define ADC_CALC_DEFS_SVH

// register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_RPT 8'h04
`define ADDR_THR 8'h08
`define ADDR_STS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_ACC 8'h14
`define ADDR_CNT 8'h18
`define ADDR_FLTR 8'h1C
`define ADDR_PREV 8'h20

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_DSEN_BIT 3
`define CTRL_SHIFT_LSB 4
`define CTRL_SHIFT_MSB 6
`define CTRL_ACLR_BIT 8
`define CTRL_GO_BIT 9

// status and mask fields
`define STS_THR_BIT 0
`define STS_OVF_BIT 1

// constants and reset values
`define CNT_SAT 8'hFF
`define CNT_ONE 8'h01
`define RPT_RST 8'h01
`define SHIFT_RST 3'h0
`define STS_RST 2'h0

`endif

// ===== design/adc_calc_pkg.sv
// types shared by the result computation unit
package adc_calc_pkg;
	typedef enum logic [2:0] {
		MODE_BASIC = 3'b000,
		MODE_ACCUM = 3'b001,
		MODE_AVG = 3'b010,
		MODE_BURST = 3'b011,
		MODE_LOWPASS = 3'b100
	} mode_t;
endpackage

// ===== design/adc_calc_unit.sv
// post-conversion computation unit with apb registers and interrupt
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "adc_calc_defs.svh"

module adc_calc_unit #(
	parameter int RES_W = 10,
	parameter int ACC_W = 18
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [RES_W-1:0] conversion_result, // converter result
	input wire logic result_valid, // one-cycle pulse, result is new
	input wire logic retrigger, // one-cycle pulse from trigger source
	output logic conversion_go, // one-cycle pulse, start a conversion
	output logic irq // level interrupt
);

	typedef struct packed {
		logic signed [ACC_W-1:0] result_accumulator;
		logic [7:0] sample_counter;
		logic [RES_W-1:0] previous_result;
		logic [2:0] compute_mode_sel;
		logic double_sample_enable;
		logic [2:0] filter_shift;
		logic [7:0] repeat_target;
		logic signed [ACC_W-1:0] threshold;
		logic [1:0] status;
		logic [1:0] mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic go;
		logic irq;
	} state_t;

	state_t s;
	state_t next_s;
	logic wr;
	logic go_wr;
	logic accumulator_clear;
	logic clr;
	logic lowpass;
	logic thr_test;
	logic signed [ACC_W-1:0] acc_base;
	logic [7:0] cnt_base;
	logic signed [ACC_W-1:0] sample;
	logic signed [ACC_W-1:0] filter_output;
	logic signed [ACC_W-1:0] decay;
	logic signed [ACC_W:0] sum;
	logic signed [ACC_W-1:0] test_value;
	logic [1:0] events;
	logic [1:0] w1c;

	// arithmetic shift drops the low bits, so the quotient is truncated
	// truncating shift
	assign filter_output = s.result_accumulator >>> s.filter_shift;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.go = 1'b0;
		wr = psel && penable && s.pready && pwrite;
		go_wr = 1'b0;
		accumulator_clear = 1'b0;
		w1c = 2'h0;
		// setup phase: answer in the next cycle with data or error
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0000_0000;
			case (paddr)
				`ADDR_CTRL: begin
					next_s.prdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = s.compute_mode_sel;
					next_s.prdata[`CTRL_DSEN_BIT] = s.double_sample_enable;
					next_s.prdata[`CTRL_SHIFT_MSB:`CTRL_SHIFT_LSB] = s.filter_shift;
				end
				`ADDR_RPT: next_s.prdata[7:0] = s.repeat_target;
				`ADDR_THR: next_s.prdata = 32'(s.threshold);
				`ADDR_STS: next_s.prdata[1:0] = s.status;
				`ADDR_MASK: next_s.prdata[1:0] = s.mask;
				`ADDR_ACC: next_s.prdata = 32'(s.result_accumulator);
				`ADDR_CNT: next_s.prdata[7:0] = s.sample_counter;
				`ADDR_FLTR: next_s.prdata = 32'(filter_output);
				`ADDR_PREV: next_s.prdata[RES_W-1:0] = s.previous_result;
				default: next_s.pslverr = 1'b1;
			endcase
		end
		// register writes take effect at the completing edge
		if (wr) begin
			case (paddr)
				`ADDR_CTRL: begin
					next_s.compute_mode_sel = pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
					next_s.double_sample_enable = pwdata[`CTRL_DSEN_BIT];
					next_s.filter_shift = pwdata[`CTRL_SHIFT_MSB:`CTRL_SHIFT_LSB];
					accumulator_clear = pwdata[`CTRL_ACLR_BIT];
					go_wr = pwdata[`CTRL_GO_BIT];
				end
				`ADDR_RPT: next_s.repeat_target = pwdata[7:0];
				`ADDR_THR: next_s.threshold = pwdata[ACC_W-1:0];
				`ADDR_STS: w1c = pwdata[1:0];
				`ADDR_MASK: next_s.mask = pwdata[1:0];
				default: ;
			endcase
		end
		clr = accumulator_clear;
		if (s.compute_mode_sel == adc_calc_pkg::MODE_BURST && (go_wr || retrigger)) begin
			clr = 1'b1;
		end
		if (s.compute_mode_sel == adc_calc_pkg::MODE_AVG && (go_wr || retrigger)
			&& s.sample_counter >= s.repeat_target) begin
			clr = 1'b1;
		end
		acc_base = clr ? '0 : s.result_accumulator;
		cnt_base = clr ? 8'h00 : s.sample_counter;
		next_s.result_accumulator = acc_base;
		next_s.sample_counter = cnt_base;
		if (go_wr) begin
			next_s.go = 1'b1;
		end
		sample = ACC_W'({1'b0, conversion_result});
		if (s.double_sample_enable) begin
			sample = ACC_W'({1'b0, conversion_result}) - ACC_W'({1'b0, s.previous_result});
		end
		lowpass = s.compute_mode_sel == adc_calc_pkg::MODE_LOWPASS;
		// kept out of a conditional: an unsigned arm would make the shift logical
		decay = '0;
		if (lowpass) begin
			decay = acc_base >>> s.filter_shift;
		end
		sum = {acc_base[ACC_W-1], acc_base} + {sample[ACC_W-1], sample} - {decay[ACC_W-1], decay};
		events = 2'h0;
		thr_test = 1'b0;
		test_value = sample;
		if (result_valid) begin
			next_s.previous_result = conversion_result;
			if (s.compute_mode_sel != adc_calc_pkg::MODE_BASIC) begin
				// one sum in every accumulating mode; decay is subtracted only in lowpass
				next_s.result_accumulator = sum[ACC_W-1:0];
				events[`STS_OVF_BIT] = sum[ACC_W] != sum[ACC_W-1];
			end
			case (s.compute_mode_sel)
				adc_calc_pkg::MODE_BASIC: thr_test = 1'b1;
				adc_calc_pkg::MODE_ACCUM: begin
					next_s.sample_counter = (cnt_base == `CNT_SAT) ? cnt_base : cnt_base + `CNT_ONE;
					thr_test = 1'b1;
				end
				adc_calc_pkg::MODE_AVG: begin
					next_s.sample_counter = (cnt_base >= s.repeat_target) ? `CNT_ONE : cnt_base + `CNT_ONE;
				end
				adc_calc_pkg::MODE_BURST: begin
					// count up, repeat while below target
					next_s.sample_counter = cnt_base + `CNT_ONE;
					if (next_s.sample_counter < s.repeat_target) begin
						next_s.go = 1'b1;
					end
				end
				adc_calc_pkg::MODE_LOWPASS: begin
					next_s.sample_counter = (cnt_base == `CNT_SAT) ? cnt_base : cnt_base + `CNT_ONE;
				end
				default: ;
			endcase
			if (s.compute_mode_sel != adc_calc_pkg::MODE_BASIC && s.compute_mode_sel != adc_calc_pkg::MODE_ACCUM) begin
				thr_test = next_s.sample_counter >= s.repeat_target;
			end
			if (s.compute_mode_sel != adc_calc_pkg::MODE_BASIC) begin
				test_value = next_s.result_accumulator >>> s.filter_shift;
			end
			// burst flag only at target, so the counter then equals it
			events[`STS_THR_BIT] = thr_test && (test_value >= s.threshold);
		end
		// a new event wins over a write-one clear in the same cycle
		next_s.status = (s.status & ~w1c) | events;
		next_s.irq = |(next_s.status & next_s.mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.repeat_target <= `RPT_RST;
			s.filter_shift <= `SHIFT_RST;
			s.status <= `STS_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign conversion_go = s.go;
	assign irq = s.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	logic is_burst;
	logic is_accum;
	assign is_burst = s.compute_mode_sel == adc_calc_pkg::MODE_BURST;
	assign is_accum = s.compute_mode_sel == adc_calc_pkg::MODE_ACCUM;

	property p_burst_clear;
		is_burst && go_wr && !result_valid |=> s.sample_counter == 8'h00 && s.result_accumulator == '0;
	endproperty
	a_burst_clear: assert property (p_burst_clear) else $error("burst go did not clear");

	property p_burst_repeat;
		is_burst && result_valid && !clr && s.sample_counter + 8'h01 < s.repeat_target
			|=> conversion_go ##1 !conversion_go;
	endproperty
	a_burst_repeat: assert property (p_burst_repeat) else $error("burst did not repeat");

	property p_burst_stop;
		is_burst && result_valid && !go_wr && !clr && s.sample_counter + 8'h01 >= s.repeat_target |=> !conversion_go;
	endproperty
	a_burst_stop: assert property (p_burst_stop) else $error("burst repeated past target");

	property p_burst_sum;
		is_burst && result_valid && !clr |=> s.result_accumulator == $past(sum[ACC_W-1:0]);
	endproperty
	a_burst_sum: assert property (p_burst_sum) else $error("burst sum wrong");

	property p_single;
		is_accum && result_valid && !clr && !s.double_sample_enable
			|=> s.result_accumulator == $past(s.result_accumulator) + ACC_W'({1'b0, $past(conversion_result)});
	endproperty
	a_single: assert property (p_single) else $error("single sample not added");

	property p_double;
		is_accum && result_valid && !clr && s.double_sample_enable
			|=> s.result_accumulator == $past(s.result_accumulator) + ACC_W'({1'b0, $past(conversion_result)})
				- ACC_W'({1'b0, $past(s.previous_result)});
	endproperty
	a_double: assert property (p_double) else $error("difference not added");

	property p_filter_trunc;
		s.filter_shift == 3'h1 |-> {filter_output[ACC_W-2:0], s.result_accumulator[0]} == s.result_accumulator;
	endproperty
	a_filter_trunc: assert property (p_filter_trunc) else $error("filter output not truncated");

	property p_flag_count;
		is_burst && $rose(s.status[`STS_THR_BIT]) && !$past(go_wr) && !$past(retrigger)
			|-> s.sample_counter == s.repeat_target;
	endproperty
	a_flag_count: assert property (p_flag_count) else $error("burst count not at target");

	property p_sat;
		is_accum && result_valid && !clr && s.sample_counter == `CNT_SAT |=> s.sample_counter == `CNT_SAT;
	endproperty
	a_sat: assert property (p_sat) else $error("counter passed saturation");

	property p_irq;
		##1 irq == |(s.status & s.mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt out of step");

	property p_apb_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

	c_burst_end: cover property (is_burst && $rose(s.status[`STS_THR_BIT]));
	c_overflow: cover property ($rose(s.status[`STS_OVF_BIT]));
	c_lowpass: cover property (s.compute_mode_sel == adc_calc_pkg::MODE_LOWPASS && result_valid);
	c_err: cover property (pslverr);

endmodule // adc_calc_unit

// ===== dv/adc_conv_model.sv
// converter model: returns one result per start pulse after a set latency
`timescale 1ns/10ps
module adc_conv_model (
	input wire logic clk_sys, // system clock
	input wire logic rst, // reset, active high
	input wire logic conversion_go, // start pulse from the unit
	input wire logic [9:0] sample_in, // value the next result carries
	input wire logic [7:0] latency, // cycles from start to result
	output logic [9:0] conversion_result, // result bus
	output logic result_valid // one-cycle result strobe
);
	logic busy;
	logic [7:0] wait_cnt;
	// one conversion in flight; idle bus toggles so a stale value is never mistaken for data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			wait_cnt <= 8'h00;
			result_valid <= 1'b0;
			conversion_result <= 10'h000;
		end else begin
			result_valid <= 1'b0;
			conversion_result <= ~conversion_result;
			if (conversion_go) begin
				busy <= 1'b1;
				wait_cnt <= latency;
			end else if (busy && wait_cnt <= 8'h01) begin
				busy <= 1'b0;
				result_valid <= 1'b1;
				conversion_result <= sample_in;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 8'h01;
			end
		end
	end
endmodule // adc_conv_model

// ===== dv/tb.sv
// self-checking bench for the result computation unit
`timescale 1ns/10ps
`include "adc_calc_defs.svh"
module tb;
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, result_valid, retrigger, conversion_go, irq, err;
	logic [7:0] paddr, lat;
	logic [31:0] pwdata, prdata, ctrl, rdv;
	logic [9:0] conversion_result, sample_in;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	adc_calc_unit dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conversion_result(conversion_result), .result_valid(result_valid), .retrigger(retrigger),
		.conversion_go(conversion_go), .irq(irq));
	adc_conv_model conv_u (.clk_sys(clk_sys), .rst(rst), .conversion_go(conversion_go), .sample_in(sample_in),
		.latency(lat), .conversion_result(conversion_result), .result_valid(result_valid));
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'h0, pready}, 32'h1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	// start one conversion and wait for its result to be taken
	task automatic conv(input logic [9:0] v);
		int n;
		n = 0;
		sample_in <= v;
		apb(1'b1, `ADDR_CTRL, ctrl | 32'h200);
		do begin
			@(posedge clk_sys);
			n++;
		end while (result_valid !== 1'b1 && n < 100);
		chk({31'h0, result_valid}, 32'h1);
	endtask
	// irq is registered, so let two edges pass before looking
	task automatic irq_chk(input logic e);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// cycle ceiling ends a hung run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		{rst, psel, penable, pwrite, retrigger} = 5'h10;
		paddr = 8'h00;
		pwdata = 32'h0;
		sample_in = 10'h000;
		lat = 8'h01;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`ADDR_RPT, 32'h1);
		rd(`ADDR_CNT, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		// accumulate mode, single sample
		ctrl = 32'h01;
		conv(10'h005);
		conv(10'h007);
		rd(`ADDR_ACC, 32'hC);
		rd(`ADDR_CNT, 32'h2);
		// double sample: differences, then truncating shift
		ctrl = 32'h09;
		apb(1'b1, `ADDR_CTRL, 32'h109);
		conv(10'h00A);
		conv(10'h011);
		rd(`ADDR_ACC, 32'hA);
		rd(`ADDR_PREV, 32'h11);
		apb(1'b1, `ADDR_CTRL, 32'h29);
		rd(`ADDR_FLTR, 32'h2);
		// basic mode leaves accumulator and counter alone
		ctrl = 32'h00;
		conv(10'h064);
		rd(`ADDR_ACC, 32'hA);
		rd(`ADDR_CNT, 32'h2);
		// average mode wraps after reaching the target
		ctrl = 32'h02;
		apb(1'b1, `ADDR_RPT, 32'h2);
		apb(1'b1, `ADDR_CTRL, 32'h102);
		conv(10'h004);
		conv(10'h004);
		conv(10'h006);
		rd(`ADDR_ACC, 32'h6);
		rd(`ADDR_CNT, 32'h1);
		// lowpass update with shift 1
		ctrl = 32'h14;
		apb(1'b1, `ADDR_CTRL, 32'h114);
		conv(10'h009);
		conv(10'h009);
		rd(`ADDR_ACC, 32'hE);
		rd(`ADDR_FLTR, 32'h7);
		// accumulate counter saturates
		ctrl = 32'h01;
		apb(1'b1, `ADDR_CTRL, 32'h101);
		repeat (257) conv(10'h000);
		rd(`ADDR_CNT, 32'hFF);
		// burst of three from one go write, threshold interrupt
		ctrl = 32'h03;
		apb(1'b1, `ADDR_STS, 32'h3);
		rd(`ADDR_STS, 32'h0);
		apb(1'b1, `ADDR_CTRL, 32'h103);
		apb(1'b1, `ADDR_RPT, 32'h3);
		apb(1'b1, `ADDR_THR, 32'h0);
		apb(1'b1, `ADDR_MASK, 32'h1);
		conv(10'h005);
		repeat (60) @(posedge clk_sys);
		rd(`ADDR_ACC, 32'hF);
		rd(`ADDR_CNT, 32'h3);
		rd(`ADDR_STS, 32'h1);
		irq_chk(1'b1);
		apb(1'b1, `ADDR_MASK, 32'h0);
		irq_chk(1'b0);
		apb(1'b1, `ADDR_MASK, 32'h1);
		irq_chk(1'b1);
		apb(1'b1, `ADDR_STS, 32'h1);
		irq_chk(1'b0);
		// slow converter: a retrigger mid-burst clears, then the burst counts again to target
		lat <= 8'h28;
		sample_in <= 10'h009;
		apb(1'b1, `ADDR_CTRL, 32'h203);
		rd(`ADDR_ACC, 32'h0);
		rd(`ADDR_CNT, 32'h0);
		repeat (50) @(posedge clk_sys);
		rd(`ADDR_ACC, 32'h9);
		rd(`ADDR_CNT, 32'h1);
		retrigger <= 1'b1;
		@(posedge clk_sys);
		retrigger <= 1'b0;
		rd(`ADDR_ACC, 32'h0);
		rd(`ADDR_CNT, 32'h0);
		repeat (200) @(posedge clk_sys);
		rd(`ADDR_ACC, 32'h1B);
		rd(`ADDR_CNT, 32'h3);
		apb(1'b1, `ADDR_CTRL, 32'h103);
		rd(`ADDR_ACC, 32'h0);
		print_verdict();
	end
endmodule // tb
